// ===== rtl/fan_stage_pkg.sv
package fan_stage_pkg;
    // register indices on the plain register port
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_SETPOINT = 5'h01;
    localparam logic [4:0] REG_ROOM_TEMP = 5'h02;
    localparam logic [4:0] REG_HYSTERESIS = 5'h03;
    localparam logic [4:0] REG_GAIN = 5'h04;
    localparam logic [4:0] REG_PERIOD = 5'h05;
    localparam logic [4:0] REG_STATUS = 5'h06;
    localparam logic [4:0] REG_THRESHOLD0 = 5'h08;
    localparam logic [4:0] REG_LIMIT0 = 5'h10;
    // control fields
    localparam int CTL_COOLING = 0;
    localparam int CTL_PROPORTIONAL = 1;
    localparam int CTL_SCALING = 2;
    localparam int CTL_LEVELS_LSB = 4;
    localparam int STAGES = 5;
    // reset values; temperatures are signed tenths of a kelvin
    localparam logic [6:0] CONTROL_RESET = 7'h50;
    localparam logic [15:0] SETPOINT_RESET = 16'h00C8;
    localparam logic [15:0] HYSTERESIS_RESET = 16'h0005;
    localparam logic [15:0] GAIN_RESET = 16'h0014;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [4:0][15:0] THRESHOLD_RESET = {16'h0028, 16'h001E, 16'h0014, 16'h000A, 16'h0000};
    localparam logic [4:0][7:0] LIMIT_RESET = {8'h5A, 8'h46, 8'h32, 8'h14, 8'h01};
    localparam logic [7:0] FULL_SCALE = 8'h64;
    localparam int TENTHS_PER_K = 10;
    // one second of the 40 MHz clock
    localparam int CLOCK_HZ = 40000000;
    localparam int SECOND_S = 1;
    localparam int SECOND_CYCLES = CLOCK_HZ * SECOND_S;
endpackage

// ===== rtl/fan_stage_controller.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
//Contract
//- in heating a stage turns on below setpoint minus threshold minus hysteresis and off at setpoint minus threshold.
//- in cooling a stage turns on above setpoint plus threshold plus hysteresis and off at setpoint plus threshold.
//- only the highest demanded stage is driven, lower stages give way to it.
//- the first stage threshold comes out of reset as zero kelvin.
//- enumerated encoding sends the stage number itself as the fan level byte.
//- scaling encoding sends the level-limit percentage of the computed stage instead.
//- proportional heating error is setpoint minus room temperature.
//- proportional cooling error is room temperature minus setpoint.
//- the control variable is the proportional gain times the error.
//- proportional mode picks the highest level whose limit the control output exceeds.
//- a gain of g percent per kelvin gives a band of 100/g kelvin at which the output reaches 100 percent.
module fan_stage_controller #(
    parameter int SECOND_CYCLES_P = fan_stage_pkg::SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic [7:0] fan_level,
    output logic fan_level_send
);
    import fan_stage_pkg::*;

    typedef struct packed {
        logic [6:0] control;
        logic [15:0] setpoint;
        logic [15:0] room_temp;
        logic [15:0] hysteresis;
        logic [15:0] gain;
        logic [15:0] period;
        logic [4:0][15:0] threshold;
        logic [4:0][7:0] limit;
        logic [4:0] stage_on;
        logic [2:0] level;
        logic [7:0] fan_level;
        logic send;
        logic [15:0] rdata;
        logic [25:0] tick_count;
        logic [15:0] seconds;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic signed [17:0] widen(input logic [15:0] v);
        widen = {{2{v[15]}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic cooling;
    logic proportional;
    logic scaling;
    logic [2:0] levels;
    logic signed [17:0] error;
    logic signed [35:0] product;
    logic [7:0] control_pct;
    logic [2:0] demand;
    logic [2:0] prop_level;
    logic [4:0] next_on;

    assign cooling = st.control[CTL_COOLING];
    assign proportional = st.control[CTL_PROPORTIONAL];
    assign scaling = st.control[CTL_SCALING];
    // a level count above five is treated as five
    assign levels = (st.control[CTL_LEVELS_LSB +: 3] > 3'(STAGES)) ? 3'(STAGES) : st.control[CTL_LEVELS_LSB +: 3];

    // error sign follows the operating direction
    always_comb begin
        if (cooling) begin
            error = widen(st.room_temp) - widen(st.setpoint);
        end else begin
            error = widen(st.setpoint) - widen(st.room_temp);
        end
    end

    // gain is percent per kelvin, error in tenths, so the band is 100/gain kelvin
    always_comb begin
        product = 36'(error) * $signed({2'b00, st.gain});
        if (product <= 0) begin
            control_pct = 8'h00;
        end else if (product >= 36'(FULL_SCALE) * 36'(TENTHS_PER_K)) begin
            control_pct = FULL_SCALE;
        end else begin
            control_pct = 8'(product / 36'(TENTHS_PER_K));
        end
    end

    // two-point hysteresis per stage, then the highest stage wins
    always_comb begin
        logic signed [17:0] edge_t;
        logic signed [17:0] on_t;
        edge_t = '0;
        on_t = '0;
        next_on = st.stage_on;
        demand = 3'h0;
        prop_level = 3'h0;
        for (int i = 0; i < STAGES; i++) begin
            if (cooling) begin
                edge_t = widen(st.setpoint) + widen(st.threshold[i]);
                on_t = edge_t + widen(st.hysteresis);
                if (widen(st.room_temp) > on_t) next_on[i] = 1'b1;
                else if (widen(st.room_temp) <= edge_t) next_on[i] = 1'b0;
            end else begin
                edge_t = widen(st.setpoint) - widen(st.threshold[i]);
                on_t = edge_t - widen(st.hysteresis);
                if (widen(st.room_temp) < on_t) next_on[i] = 1'b1;
                else if (widen(st.room_temp) >= edge_t) next_on[i] = 1'b0;
            end
            if (3'(i) >= levels) next_on[i] = 1'b0;
            if (next_on[i]) demand = 3'(i + 1);
            if (3'(i) < levels && control_pct > st.limit[i]) prop_level = 3'(i + 1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state: register writes, control, periodic resend, read data
    always_comb begin
        logic [2:0] lvl;
        logic tick;
        logic periodic;
        lvl = 3'h0;
        tick = 1'b0;
        periodic = 1'b0;
        next_st = st;
        next_st.send = 1'b0;
        next_st.rdata = 16'h0000;
        if (reg_write) begin
            unique case (reg_addr)
                REG_CONTROL: next_st.control = reg_wdata[6:0];
                REG_SETPOINT: next_st.setpoint = reg_wdata;
                REG_ROOM_TEMP: next_st.room_temp = reg_wdata;
                REG_HYSTERESIS: next_st.hysteresis = reg_wdata;
                REG_GAIN: next_st.gain = reg_wdata;
                REG_PERIOD: next_st.period = reg_wdata;
                default: begin
                    for (int i = 0; i < STAGES; i++) begin
                        if (reg_addr == REG_THRESHOLD0 + 5'(i)) next_st.threshold[i] = reg_wdata;
                        if (reg_addr == REG_LIMIT0 + 5'(i)) next_st.limit[i] = reg_wdata[7:0];
                    end
                end
            endcase
        end
        if (reg_read) begin
            unique case (reg_addr)
                REG_CONTROL: next_st.rdata = {9'h000, st.control};
                REG_SETPOINT: next_st.rdata = st.setpoint;
                REG_ROOM_TEMP: next_st.rdata = st.room_temp;
                REG_HYSTERESIS: next_st.rdata = st.hysteresis;
                REG_GAIN: next_st.rdata = st.gain;
                REG_PERIOD: next_st.rdata = st.period;
                REG_STATUS: next_st.rdata = {st.fan_level, control_pct[6:0], 1'b0} | {13'h0000, st.level};
                default: begin
                    for (int i = 0; i < STAGES; i++) begin
                        if (reg_addr == REG_THRESHOLD0 + 5'(i)) next_st.rdata = st.threshold[i];
                        if (reg_addr == REG_LIMIT0 + 5'(i)) next_st.rdata = {8'h00, st.limit[i]};
                    end
                end
            endcase
        end
        // stage state keeps running in both modes so a mode switch starts clean
        next_st.stage_on = next_on;
        lvl = proportional ? prop_level : demand;
        next_st.level = lvl;
        if (lvl == 3'h0) begin
            next_st.fan_level = 8'h00;
        end else if (scaling) begin
            next_st.fan_level = st.limit[lvl - 3'h1];
        end else begin
            next_st.fan_level = {5'h00, lvl};
        end
        // one-second enable from a divider, then a seconds count
        tick = (st.tick_count == 26'(SECOND_CYCLES_P - 1));
        next_st.tick_count = tick ? 26'h0000000 : st.tick_count + 26'h0000001;
        if (st.period == 16'h0000) begin
            next_st.seconds = 16'h0000;
        end else if (tick) begin
            periodic = (st.seconds + 16'h0001 >= st.period);
            next_st.seconds = periodic ? 16'h0000 : st.seconds + 16'h0001;
        end
        // a changed value goes out at once, an unchanged one on the period
        next_st.send = periodic || (next_st.fan_level != st.fan_level);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.control <= CONTROL_RESET;
            st.setpoint <= SETPOINT_RESET;
            st.room_temp <= SETPOINT_RESET;
            st.hysteresis <= HYSTERESIS_RESET;
            st.gain <= GAIN_RESET;
            st.period <= PERIOD_RESET;
            st.threshold <= THRESHOLD_RESET;
            st.limit <= LIMIT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign fan_level = st.fan_level;
    assign fan_level_send = st.send;

    ////////////////////////////////////////////////////////////////////////
    first_threshold_a: assert property (@(posedge clk) $rose(rst_n) |-> st.threshold[0] == 16'h0000)
        else $error("first stage threshold not zero after reset");
    heat_error_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cooling |-> (error > 18'sd0) == (widen(st.room_temp) < widen(st.setpoint)))
        else $error("heating error sign wrong");
    cool_error_a: assert property (@(posedge clk) disable iff (!rst_n)
        cooling |-> (error > 18'sd0) == (widen(st.room_temp) > widen(st.setpoint)))
        else $error("cooling error sign wrong");
    clamp_range_a: assert property (@(posedge clk) disable iff (!rst_n) control_pct <= FULL_SCALE)
        else $error("control output above full scale");
    band_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (st.gain != 16'h0000 && error > 18'sd0 && 36'(error) * 36'(st.gain) >= 36'(1000)) |->
        control_pct == FULL_SCALE)
        else $error("error at band did not give full output");
    heat_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!cooling && !reg_write && widen(st.room_temp) >= widen(st.setpoint) - widen(st.threshold[0]))
        |=> !st.stage_on[0]) else $error("heating stage one stayed on at threshold");
    cool_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cooling && !reg_write && levels != 3'h0 && widen(st.room_temp) >
        widen(st.setpoint) + widen(st.threshold[0]) + widen(st.hysteresis)) |=> st.stage_on[0])
        else $error("cooling stage one not switched on");
    top_stage_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!$past(proportional) && st.level != 3'h0) |->
        st.stage_on[st.level - 3'h1] && (st.stage_on >> st.level) == 5'h00)
        else $error("driven stage is not the highest demanded");
    enum_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(scaling) && $past(rst_n) |-> st.fan_level == {5'h00, st.level}) else $error("enumerated level mismatch");
    scale_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(scaling) && $past(rst_n) && st.level != 3'h0 |-> st.fan_level == $past(st.limit[next_st.level - 3'h1]))
        else $error("scaled level mismatch");
    no_periodic_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.period == 16'h0000 |=> st.seconds == 16'h0000) else $error("periodic count runs while disabled");
endmodule

// ===== verification/fan_actuator_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far-side fan actuator: it applies the level byte only when a send pulse marks a telegram
module fan_actuator_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] fan_level,
    input wire logic fan_level_send,
    output logic [7:0] applied_level,
    output int frames
);
    // a level change with no send pulse never reaches the actuator, so it is ignored here too
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_level <= 8'h00;
            frames <= 0;
        end else if (fan_level_send) begin
            applied_level <= fan_level;
            frames <= frames + 1;
        end
    end
endmodule

// ===== verification/fan_stage_controller_tb.sv
`timescale 1ns/1ps
module fan_stage_controller_tb;
    import fan_stage_pkg::*;
    localparam int SEC_P = 10; // shortened second keeps the periodic test brief
    logic clk, rst_n, reg_write, reg_read, fan_level_send;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [7:0] fan_level, applied_level;
    int frames, err_count, n_compared, sp, lvl, prev;
    int thr[5] = '{0, 10, 20, 30, 40};
    int lim[5] = '{1, 20, 50, 70, 90};
    int corner[10] = '{195, 194, 199, 200, 190, 184, 130, 160, 229, 200};
    bit on[5];

    fan_stage_controller #(.SECOND_CYCLES_P(SEC_P)) u_fan_stage_controller (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .fan_level(fan_level), .fan_level_send(fan_level_send));
    fan_actuator_model u_fan_actuator_model (.clk(clk), .rst_n(rst_n), .fan_level(fan_level),
        .fan_level_send(fan_level_send), .applied_level(applied_level), .frames(frames));

    ////////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // register port: one-cycle strobes launched just after an edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata; // data stand only in the cycle after the strobe
    endtask

    // reference: both directions fold into one error, two-point stages keep their own hysteresis state
    function automatic int expect_level(int t, int ctl);
        int err, out, best;
        best = 0;
        err = ctl[0] ? t - sp : sp - t;
        out = int'(GAIN_RESET) * err / TENTHS_PER_K;
        out = out < 0 ? 0 : (out > 100 ? 100 : out);
        for (int i = 0; i < STAGES; i++) begin
            if (ctl[1]) begin
                if (out > lim[i]) best = i + 1;
            end else begin
                on[i] = on[i] ? (err > thr[i]) : (err > thr[i] + int'(HYSTERESIS_RESET));
                if (on[i]) best = i + 1;
            end
        end
        return (ctl[2] && best > 0) ? lim[best - 1] : best;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int t;
        logic [15:0] v;
        rst_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        err_count = 0;
        n_compared = 0;
        sp = int'(SETPOINT_RESET);
        void'($urandom(71));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(REG_THRESHOLD0, v);
        check(v, 16'h0000);
        rd(REG_CONTROL, v);
        check(v, {9'h000, CONTROL_RESET});
        rd(5'h1F, v);
        check(v, 16'h0000);
        check({8'h00, fan_level}, 16'h0000);
        $display("test reset values done");
        // every mode and encoding: corners first, then random temperatures around the setpoint
        for (int ctl = 0; ctl < 8; ctl++) begin
            wr(REG_ROOM_TEMP, 16'(sp)); // at the setpoint every stage is off in both directions
            wr(REG_CONTROL, 16'h0050 | 16'(ctl));
            on = '{default: 0};
            prev = 0;
            repeat (2) @(posedge clk);
            for (int k = 0; k < 26; k++) begin
                t = k < 10 ? (ctl[0] ? 400 - corner[k] : corner[k]) : sp + int'($urandom_range(140)) - 70;
                lvl = expect_level(t, ctl);
                wr(REG_ROOM_TEMP, 16'(t));
                @(posedge clk);
                #1 check({8'h00, fan_level}, 16'(lvl));
                check({15'h0000, fan_level_send}, {15'h0000, lvl != prev});
                prev = lvl;
            end
            @(posedge clk);
            #1 check({8'h00, applied_level}, 16'(lvl));
            $display("test mode %0d done", ctl);
        end
        // level count field: three levels cap a deep demand at three, a count above five acts as five
        wr(REG_CONTROL, 16'h0030);
        wr(REG_ROOM_TEMP, 16'(sp - 100));
        @(posedge clk);
        #1 check({8'h00, fan_level}, 16'h0003);
        wr(REG_CONTROL, 16'h0070);
        @(posedge clk);
        #1 check({8'h00, fan_level}, 16'h0005);
        wr(REG_ROOM_TEMP, 16'(sp));
        repeat (2) @(posedge clk);
        #1 check({8'h00, fan_level}, 16'h0000);
        $display("test level count done");
        // periodic resend: a period of two shortened seconds gives five sends in 100 cycles, zero gives none
        wr(REG_PERIOD, 16'h0002);
        repeat (3) @(posedge clk);
        t = frames;
        repeat (100) @(posedge clk);
        check(16'(frames - t), 16'h0005);
        wr(REG_PERIOD, 16'h0000);
        repeat (3) @(posedge clk);
        t = frames;
        repeat (100) @(posedge clk);
        check(16'(frames - t), 16'h0000);
        $display("test periodic send done");
        complete_run();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule
